// File: core/psarb_regs.svh
// Constants for the slot bus round-robin arbiter
`ifndef PSARB_REGS_SVH
`define PSARB_REGS_SVH

`define PSARB_NUM_SLOTS 3
`define PSARB_BUS_MHZ 33
`define PSARB_SLOT_BUS_NUM 8'h07
`define PSARB_SEL_BIT_SLOT1 20
`define PSARB_SEL_BIT_SLOT2 25
`define PSARB_SEL_BIT_SLOT3 27
`define PSARB_GNT_IDLE 3'h7

`endif

// File: core/psarb_pkg.sv
// Types for the slot bus round-robin arbiter
package psarb_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_GRANT = 3'b010,
    ST_TURN  = 3'b100
  } psarb_state_t;

  // Bus pins sampled by the arbiter, all active low except the selects
  typedef struct packed {
    logic [2:0] reqN;
    logic frameN;
    logic irdyN;
    logic [2:0] adSel;
  } psarb_pins_t;

  typedef struct packed {
    psarb_state_t st;
    logic [1:0] owner;
    logic [2:0] gntN;
    psarb_pins_t s1;
    psarb_pins_t s2;
    logic [2:0] idsel;
  } psarb_core_t;

endpackage

// File: core/psarb_arbiter.sv
// Round-robin request/grant arbiter for three expansion slots
`timescale 1ns/1ps
`include "psarb_regs.svh"

module psarb_arbiter
  import psarb_pkg::*;
#(
  parameter logic [2:0] SLOT_PRESENT = 3'h7,
  parameter logic [2:0] NO_PARK_MASK = 3'h0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request pins, index is the pair number
  input wire logic [2:0] reqN,
  // Bus activity pins
  input wire logic frameN,
  input wire logic irdyN,
  // Address/data bus during configuration cycles
  input wire logic [31:0] ad,
  // Grant pins, index is the pair number
  output logic [2:0] gntN,
  // Per-slot configuration select
  output logic [2:0] slotIdsel
);

  localparam psarb_core_t CORE_RST = '{
    st: ST_IDLE,
    owner: 2'h0,
    gntN: `PSARB_GNT_IDLE,
    s1: '{reqN: 3'h7, frameN: 1'b1, irdyN: 1'b1, adSel: 3'h0},
    s2: '{reqN: 3'h7, frameN: 1'b1, irdyN: 1'b1, adSel: 3'h0},
    idsel: 3'h0
  };

  psarb_core_t q_r;
  psarb_core_t q_nxt;
  psarb_pins_t pinsIn;
  logic [2:0] req;
  logic [2:0] others;
  logic busIdle;
  logic [1:0] pick;

  // Next requester after the last owner, walking the slots cyclically
  function automatic logic [1:0] rr_pick(input logic [2:0] r, input logic [1:0] last);
    logic [1:0] idx;
    logic found;
    idx = last;
    found = 1'b0;
    rr_pick = last;
    for (int i = 1; i <= `PSARB_NUM_SLOTS; i++) begin
      idx = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
      if (!found && r[idx]) begin
        rr_pick = idx;
        found = 1'b1;
      end
    end
  endfunction

  // Active-low one-hot grant word for a pair index
  function automatic logic [2:0] gnt_word(input logic [1:0] idx);
    gnt_word = ~(3'h1 << idx);
  endfunction

  // AD bits are synced one by one, so selects may skew a clock while AD moves
  // Slot to pair mapping is by index; requests of absent slots are masked, their selects are not
  // Config selects come from fixed AD bits on every clock; the bus number is not decoded
  always_comb begin
    pinsIn.reqN = reqN;
    pinsIn.frameN = frameN;
    pinsIn.irdyN = irdyN;
    pinsIn.adSel = {ad[`PSARB_SEL_BIT_SLOT3], ad[`PSARB_SEL_BIT_SLOT2],
                    ad[`PSARB_SEL_BIT_SLOT1]};
  end

  always_comb begin
    req = ~q_r.s2.reqN & SLOT_PRESENT;
    others = req & ~(3'h1 << q_r.owner);
    busIdle = q_r.s2.frameN & q_r.s2.irdyN;
    pick = rr_pick(req, q_r.owner);
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pinsIn;
    q_nxt.s2 = q_r.s1;
    q_nxt.idsel = q_r.s2.adSel;
    unique case (q_r.st)
      ST_IDLE: begin
        // Nothing granted until someone asks the asker wins
        if (|req) begin
          q_nxt.owner = pick;
          q_nxt.gntN = gnt_word(pick);
          q_nxt.st = ST_GRANT;
        end
      end
      ST_GRANT: begin
        // Bus view lags two clocks, so a fresh owner may lose a grant it never used
        // Hand over only between transactions, or at once if owner dropped out
        if (|others && (busIdle || !req[q_r.owner])) begin
          q_nxt.gntN = `PSARB_GNT_IDLE;
          q_nxt.st = ST_TURN;
        end else if (!req[q_r.owner] && NO_PARK_MASK[q_r.owner]) begin
          // Bridge-type agents never keep a parked grant
          q_nxt.gntN = `PSARB_GNT_IDLE;
          q_nxt.st = ST_IDLE;
        end
      end
      ST_TURN: begin
        // One dead cycle between owners keeps grants exclusive
        // Search starts past the old owner, so nobody starves
        if (|req) begin
          q_nxt.owner = pick;
          q_nxt.gntN = gnt_word(pick);
          q_nxt.st = ST_GRANT;
        end else begin
          q_nxt.st = ST_IDLE;
        end
      end
      default: begin
        q_nxt.gntN = `PSARB_GNT_IDLE;
        q_nxt.st = ST_IDLE;
      end
    endcase
  end

  // Reset is taken unsynced; its release must meet recovery against mclk
  // Everything advances on the bus clock itself
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= CORE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Grant pins come straight from the state register
  assign gntN = q_r.gntN;
  assign slotIdsel = q_r.idsel;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_single_grant: assert property ($countones(~gntN) <= 1)
    else $error("more than one grant asserted");

  chk_idle_quiet: assert property ((q_r.st == ST_IDLE && req == 3'h0) |=> gntN == 3'h7)
    else $error("grant asserted with no request");

  chk_grant_requester: assert property ((q_r.st == ST_IDLE && |req)
      |=> gntN == gnt_word($past(pick)) && $past(req[pick]))
    else $error("grant not given to the requester");

  chk_rr_rotate: assert property ((q_r.st == ST_GRANT && |others && busIdle)
      |=> q_r.st == ST_TURN ##1 (q_r.owner != $past(q_r.owner, 2)))
    else $error("round robin failed to move ownership");

  chk_park_hold: assert property ((q_r.st == ST_GRANT && others == 3'h0 && req[q_r.owner])
      |=> $stable(gntN) && q_r.st == ST_GRANT)
    else $error("parked grant dropped while uncontested");

  chk_no_park: assert property ((q_r.st == ST_GRANT && req == 3'h0
      && NO_PARK_MASK[q_r.owner]) |=> gntN == 3'h7)
    else $error("non-parking agent kept the grant");

  chk_slot_mask: assert property ((~gntN & ~SLOT_PRESENT) == 3'h0)
    else $error("grant driven to an absent slot");

  chk_idsel_map: assert property (slotIdsel == $past({ad[27], ad[25], ad[20]}, 3))
    else $error("slot select does not follow its AD bit");

  chk_turn_dead: assert property (q_r.st == ST_TURN |-> gntN == 3'h7)
    else $error("grant asserted during handover gap");

  chk_grant_owner: assert property (q_r.st == ST_GRANT
      |-> gntN == gnt_word(q_r.owner))
    else $error("grant pin does not match the owner");

  chk_owner_leaves: assert property ((q_r.st == ST_GRANT && |others
      && !req[q_r.owner]) |=> gntN == 3'h7)
    else $error("grant kept by an owner that stopped asking");

  chk_busy_hold: assert property ((q_r.st == ST_GRANT && req[q_r.owner]
      && !busIdle) |=> $stable(gntN))
    else $error("grant taken from a busy owner");

  chk_state_legal: assert property ($onehot(q_r.st))
    else $error("arbiter state is not one-hot");

  chk_req_sync: assert property (q_r.s2.reqN == $past(reqN, 2))
    else $error("request view does not lag the pins by two clocks");

  chk_bus_sync: assert property ({q_r.s2.frameN, q_r.s2.irdyN}
      == $past({frameN, irdyN}, 2))
    else $error("bus view does not lag the pins by two clocks");

  chk_absent_quiet: assert property ((q_r.st == ST_IDLE && req == 3'h0)
      |=> q_r.st == ST_IDLE)
    else $error("request of an absent slot woke the arbiter");

  chk_idle_no_grant: assert property (q_r.st == ST_IDLE |-> gntN == 3'h7)
    else $error("grant asserted while idle");

  chk_turn_exits: assert property ((q_r.st == ST_TURN && req == 3'h0)
      |=> q_r.st == ST_IDLE)
    else $error("handover gap did not fall back to idle");

  chk_turn_grants: assert property ((q_r.st == ST_TURN && |req)
      |=> gntN == gnt_word($past(pick)))
    else $error("handover did not grant the next in rotation");

  chk_pick_requests: assert property (|req |-> req[pick])
    else $error("rotation picked an agent that is not asking");

  cov_first_grant: cover property (q_r.st == ST_IDLE ##1 gntN != 3'h7);
  cov_handover: cover property (q_r.st == ST_TURN ##1 q_r.st == ST_GRANT);
  cov_all_three: cover property (req == 3'h7 && q_r.st == ST_GRANT);
  cov_park_drop: cover property (q_r.st == ST_GRANT ##1 q_r.st == ST_IDLE);
  cov_owner_leaves: cover property (q_r.st == ST_GRANT && |others && !req[q_r.owner]);

endmodule

// File: verification/psarb_card.sv
// Bus master card model sitting in one slot
`timescale 1ns/1ps
module psarb_card (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench control and grant
  input wire logic want,
  input wire logic gntN,
  // Card pins
  output logic reqN,
  output logic frameN
);
  logic busy_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reqN <= 1'b1;
      frameN <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      reqN <= !want;
      // One address phase per grant keeps the bus mostly idle
      frameN <= !(want && !gntN && !busy_r);
      busy_r <= want && !gntN;
    end
  end
endmodule

// File: verification/tb_pci_slot_bus_arbiter.sv
// Self-checking bench for the slot bus arbiter
`timescale 1ns/1ps
module tb_pci_slot_bus_arbiter;
  logic mclk = 0;
  logic rst_n = 0;
  logic [2:0] want = 0;
  logic [2:0] reqN, frm, gntN, gntN2, slotIdsel, e;
  logic [31:0] ad = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int last = 2;
  int k, p, j;
  int m2 = -1;
  always #10 mclk = ~mclk;
  for (genvar i = 0; i < 3; i++) begin : g
    psarb_card u_psarb_card (.mclk(mclk), .rst_n(rst_n), .want(want[i]),
      .gntN(gntN[i]), .reqN(reqN[i]), .frameN(frm[i]));
  end
  psarb_arbiter u_psarb_arbiter (.mclk(mclk), .rst_n(rst_n), .reqN(reqN),
    .frameN(&frm), .irdyN(1'b1), .ad(ad), .gntN(gntN), .slotIdsel(slotIdsel));
  // Two-slot variant whose second slot is a bridge-type agent that never parks
  if (1) begin : g_small
    psarb_arbiter #(.SLOT_PRESENT(3'h3), .NO_PARK_MASK(3'h2)) u_psarb_arbiter (.mclk(mclk),
      .rst_n(rst_n), .reqN(reqN), .frameN(&frm), .irdyN(1'b1), .ad(ad), .gntN(gntN2),
      .slotIdsel());
  end
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Index of the next asking pair in rotation after the last owner
  function automatic int nxt(input int l, input logic [2:0] w);
    for (int i = 1; i < 4; i++) if (w[(l + i) % 3]) return (l + i) % 3;
    return l;
  endfunction
  task automatic wait_new(input logic [2:0] old);
    k = 0;
    while ((gntN === old || gntN === 3'h7) && k < 60) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask
  always @(negedge mclk) begin
    if (rst_n) begin
      check({$countones(~gntN2) > 1, $isunknown(gntN), $countones(~gntN) > 1}, 3'h0);
      check({2'h0, gntN2[2]}, 3'h1);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    k = $urandom(25);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 check(gntN, 3'h7);
    check(gntN2, 3'h7);
    for (j = 0; j < 8; j++) begin
      @(posedge mclk);
      p = $urandom % 3;
      want <= 3'h1 << p;
      e = ~(3'h1 << p);
      #1 if (gntN !== e) wait_new(gntN);
      check(gntN, e);
      last = p;
      // Small variant ignores slot three and drops slot two once it stops asking
      if (p != 2) m2 = (p == 1) ? -1 : 0;
      @(posedge mclk);
      want <= 3'h0;
      repeat (8) @(posedge mclk);
      #1 check(gntN, e);
      check(gntN2, (m2 < 0) ? 3'h7 : ~(3'h1 << m2));
    end
    // All keep asking: every idle-bus decision moves the grant on by one
    @(posedge mclk);
    want <= 3'h7;
    for (j = 0; j < 9; j++) begin
      #1 p = nxt(last, want);
      wait_new(gntN);
      check(gntN, ~(3'h1 << p));
      last = p;
      @(posedge mclk);
    end
    want <= 3'h0;
    for (j = 0; j < 6; j++) begin
      @(posedge mclk);
      ad <= $urandom;
      repeat (4) @(posedge mclk);
      #1 check(slotIdsel, {ad[27], ad[25], ad[20]});
    end
    results();
  end
endmodule
